// >>> sdm_pkg.sv
package sdm_pkg;

  // clock and standstill timing
  localparam int CLK_MHZ = 125;
  localparam int STANDSTILL_US = 20;
  localparam int STANDSTILL_CYC = STANDSTILL_US * CLK_MHZ;

  // register byte offsets on the bus
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] VEL_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;

  // register numbers in serial frames
  localparam logic [6:0] SREG_CTRL = 7'h00;
  localparam logic [6:0] SREG_VEL = 7'h01;

  // serial frame constants
  localparam logic [3:0] SYNC_NIBBLE = 4'h5;
  localparam logic [7:0] NODE_ADDR = 8'h00;
  localparam logic [7:0] CRC_POLY = 8'h07;

  // status field positions
  localparam int STAT_SERIAL_BIT = 16;
  localparam int STAT_FAULT_BIT = 17;
  localparam int STAT_STILL_BIT = 18;
  localparam int STAT_POWER_BIT = 19;

  // synchronised pin vector layout
  localparam int PIN_N = 7;
  localparam int PIN_STEP = 0;
  localparam int PIN_DIR = 1;
  localparam int PIN_ENN = 2;
  localparam int PIN_MSLO = 3;
  localparam int PIN_MSHI = 4;
  localparam int PIN_PDN = 5;
  localparam int PIN_ERR = 6;
  localparam logic [6:0] PIN_SYNC_RESET = 7'h24;

  // microstep geometry: log2 of microsteps per full step
  localparam int POS_W = 10;
  localparam int VEL_W = 24;
  localparam logic [3:0] MRES_MAX = 4'h8;
  localparam logic [3:0] MRES_PIN_00 = 4'h3;
  localparam logic [3:0] MRES_PIN_01 = 4'h1;
  localparam logic [3:0] MRES_PIN_10 = 4'h2;
  localparam logic [3:0] MRES_PIN_11 = 4'h4;
  localparam logic [9:0] FULL_STEP_INC = 10'h100;
  localparam logic [9:0] QUARTER_OFS = 10'h100;
  localparam logic [6:0] TABLE_TOP = 7'h40;

  typedef struct packed {
    logic standstillEn;
    logic [3:0] resolution;
    logic pinOverride;
    logic dualEdge;
  } ctrl_type;

  localparam ctrl_type CTRL_RESET = '{1'b0, 4'h0, 1'b0, 1'b0};

  typedef struct packed {
    logic negA;
    logic [7:0] magA;
    logic negB;
    logic [7:0] magB;
  } coil_current_type;

  typedef enum {RX_IDLE, RX_MEAS, RX_START, RX_DATA, RX_STOP} rx_state_type;

  // one byte into the frame checksum, low bit first
  function automatic logic [7:0] crc8Byte(input logic [7:0] crc,
                                          input logic [7:0] data);
    logic [7:0] c;
    c = crc;
    for (int j = 0; j < 8; j++) begin
      if (c[7] ^ data[j]) begin
        c = {c[6:0], 1'b0} ^ CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction : crc8Byte

endpackage : sdm_pkg

// >>> sdm_sine_rom.sv
`timescale 1ns/1ps
module sdm_sine_rom (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [6:0] index,
  output logic [7:0] magnitude
);
  import sdm_pkg::*;

  // quarter sine wave, 64 segments plus the peak
  localparam logic [7:0] TABLE [0:64] = '{
    8'h00, 8'h06, 8'h0D, 8'h13, 8'h19, 8'h1F, 8'h25, 8'h2C, 8'h32, 8'h38,
    8'h3E, 8'h44, 8'h4A, 8'h50, 8'h56, 8'h5C, 8'h62, 8'h67, 8'h6D, 8'h73,
    8'h78, 8'h7E, 8'h83, 8'h88, 8'h8E, 8'h93, 8'h98, 8'h9D, 8'hA2, 8'hA7,
    8'hAB, 8'hB0, 8'hB4, 8'hB9, 8'hBD, 8'hC1, 8'hC5, 8'hC9, 8'hCD, 8'hD0,
    8'hD4, 8'hD7, 8'hDB, 8'hDE, 8'hE1, 8'hE4, 8'hE7, 8'hE9, 8'hEC, 8'hEE,
    8'hF0, 8'hF2, 8'hF4, 8'hF6, 8'hF7, 8'hF9, 8'hFA, 8'hFB, 8'hFC, 8'hFD,
    8'hFE, 8'hFE, 8'hFF, 8'hFF, 8'hFF
  };

  logic [7:0] mag_d;

  always_comb begin
    if (index <= TABLE_TOP) begin
      mag_d = TABLE[index];
    end else begin
      mag_d = TABLE[TABLE_TOP];
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      magnitude <= 8'h00;
    end else begin
      magnitude <= mag_d;
    end
  end

endmodule : sdm_sine_rom

// >>> sdm_serial_rx.sv
`timescale 1ns/1ps
module sdm_serial_rx #(
  parameter int CNT_W = 16
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic rxd,
  input wire logic measure,
  output logic byteValid,
  output logic [7:0] byteData
);
  import sdm_pkg::*;

  rx_state_type state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d, bitLen_q, bitLen_d;
  logic [7:0] shift_q, shift_d, data_d;
  logic [2:0] bitIdx_q, bitIdx_d;
  logic rxdPrev_q, valid_d;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    bitLen_d = bitLen_q;
    shift_d = shift_q;
    bitIdx_d = bitIdx_q;
    valid_d = 1'b0;
    data_d = byteData;
    case (state_q)
      RX_IDLE: begin
        if (rxdPrev_q && !rxd) begin
          cnt_d = '0;
          state_d = measure ? RX_MEAS : RX_START;
          if (!measure) begin
            cnt_d = bitLen_q >> 1;
          end
        end
      end
      // sync byte: start bit length up to the first high bit is one bit time
      RX_MEAS: begin
        cnt_d = cnt_q + 1'b1;
        if (rxd) begin
          bitLen_d = cnt_q + 1'b1;
          shift_d = 8'h80;
          bitIdx_d = 3'h1;
          cnt_d = cnt_q + ((cnt_q + 1'b1) >> 1);
          state_d = RX_DATA;
        end else if (&cnt_q) begin
          state_d = RX_IDLE;
        end
      end
      RX_START: begin
        if (cnt_q == '0) begin
          cnt_d = bitLen_q - 1'b1;
          bitIdx_d = 3'h0;
          state_d = rxd ? RX_IDLE : RX_DATA;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      RX_DATA: begin
        if (cnt_q == '0) begin
          shift_d = {rxd, shift_q[7:1]};
          cnt_d = bitLen_q - 1'b1;
          bitIdx_d = bitIdx_q + 1'b1;
          if (bitIdx_q == 3'h7) begin
            state_d = RX_STOP;
          end
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      RX_STOP: begin
        if (cnt_q == '0) begin
          valid_d = rxd;
          data_d = shift_q;
          state_d = RX_IDLE;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      default: state_d = RX_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= RX_IDLE;
      cnt_q <= '0;
      bitLen_q <= '1;
      shift_q <= 8'h00;
      bitIdx_q <= 3'h0;
      rxdPrev_q <= 1'b1;
      byteValid <= 1'b0;
      byteData <= 8'h00;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      bitLen_q <= bitLen_d;
      shift_q <= shift_d;
      bitIdx_q <= bitIdx_d;
      rxdPrev_q <= rxd;
      byteValid <= valid_d;
      byteData <= data_d;
    end
  end

endmodule : sdm_serial_rx

// >>> sdm_sequencer.sv
`timescale 1ns/1ps
// Function
// R1: rising or both step edges, configurable
// R2: direction sampled at each active edge
// R3: direction low counts up, high down
// R4: full step up to 256 microsteps
// R5: table turns count into sine, cosine
// R6: pins select a few microstep resolutions
// R7: first good frame enables serial mode
// R8: control bit overrides pin selections
// R9: serial bit rate detected automatically
// R10: single wire, 8 bit serial characters
// R11: frames carry sender generated checksum
// R12: one fixed serial node address
// R13: host shadows write only registers
// R14: velocity drives internal step generator
// R15: new velocity applies at once
// R16: external and internal stepping alternate freely
// R17: power down pin low enables reduction
// R18: disable input high switches stage off
// R19: fault set on error, cleared disabled
// R20: resolution pins decode 8, 2, 4, 16
// R21: index pulse at microstep position zero
// R22: inputs synchronised, one count per edge
// R23: counter wraps at 1024, resets zero
module sdm_sequencer (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic stepIn,
  input wire logic dirIn,
  input wire logic driverDisable_n,
  input wire logic resolutionSelectLo,
  input wire logic resolutionSelectHi,
  input wire logic powerdownSerialPinIn,
  output logic powerdownSerialPinOut,
  output logic powerdownSerialPinOe,
  input wire logic driverError,
  output logic faultOutput,
  output logic rotationIndex,
  output logic powerStageEnable,
  output logic standstillReduce,
  output sdm_pkg::coil_current_type coilCurrent
);
  import sdm_pkg::*;

  // maps pin code {hi, lo} to log2 of microsteps
  function automatic logic [3:0] pinResolution(input logic [1:0] code);
    case (code)
      2'b00: pinResolution = MRES_PIN_00;
      2'b01: pinResolution = MRES_PIN_01;
      2'b10: pinResolution = MRES_PIN_10;
      default: pinResolution = MRES_PIN_11;
    endcase
  endfunction : pinResolution

  // table index for a quarter of the electrical turn
  function automatic logic [6:0] tableIndex(input logic [9:0] angle);
    if (angle[8]) begin
      tableIndex = TABLE_TOP - {1'b0, angle[7:2]};
    end else begin
      tableIndex = {1'b0, angle[7:2]};
    end
  endfunction : tableIndex

  // pin synchronisers
  logic [PIN_N-1:0] pinRaw, pinMeta_q, pinSync_q;

  assign pinRaw = {driverError, powerdownSerialPinIn, resolutionSelectHi,
                   resolutionSelectLo, driverDisable_n, dirIn, stepIn};

  // R22 two stage sync
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pinMeta_q <= PIN_SYNC_RESET;
      pinSync_q <= PIN_SYNC_RESET;
    end else begin
      pinMeta_q <= pinRaw;
      pinSync_q <= pinMeta_q;
    end
  end

  // serial receiver and frame parser
  logic rxValid;
  logic [7:0] rxData;
  logic [2:0] byteIdx_q, byteIdx_d;
  logic frameWrite_q, frameWrite_d;
  logic [6:0] regSel_q, regSel_d;
  logic [31:0] frameData_q, frameData_d;
  logic [7:0] crc_q, crc_d, crcNext;
  logic serialActive_q, serialActive_d;
  logic sWrite_q, sWrite_d;
  logic lastByte;

  // R9 bit time relearned on each sync byte
  sdm_serial_rx u_rx (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .rxd(pinSync_q[PIN_PDN]),
    .measure(byteIdx_q == 3'h0),
    .byteValid(rxValid),
    .byteData(rxData)
  );

  assign crcNext = crc8Byte(crc_q, rxData);
  assign lastByte = frameWrite_q ? (byteIdx_q == 3'h7) : (byteIdx_q == 3'h3);

  always_comb begin
    byteIdx_d = byteIdx_q;
    frameWrite_d = frameWrite_q;
    regSel_d = regSel_q;
    frameData_d = frameData_q;
    crc_d = crc_q;
    serialActive_d = serialActive_q;
    sWrite_d = 1'b0;
    if (rxValid) begin
      crc_d = crcNext;
      byteIdx_d = byteIdx_q + 1'b1;
      if (byteIdx_q == 3'h0) begin
        // R10 sync character opens a frame
        crc_d = crc8Byte(8'h00, rxData);
        if (rxData[3:0] != SYNC_NIBBLE) begin
          byteIdx_d = 3'h0;
        end
      end else if (byteIdx_q == 3'h1) begin
        // R12 fixed node address
        if (rxData != NODE_ADDR) begin
          byteIdx_d = 3'h0;
        end
      end else if (byteIdx_q == 3'h2) begin
        frameWrite_d = rxData[7];
        regSel_d = rxData[6:0];
      end else if (lastByte) begin
        byteIdx_d = 3'h0;
        // R11 checksum must match
        if (rxData == crc_q) begin
          // R7 good frame enables serial mode
          serialActive_d = 1'b1;
          sWrite_d = frameWrite_q;
        end
      end else begin
        frameData_d = {frameData_q[23:0], rxData};
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      byteIdx_q <= 3'h0;
      frameWrite_q <= 1'b0;
      regSel_q <= 7'h00;
      frameData_q <= 32'h0000_0000;
      crc_q <= 8'h00;
      serialActive_q <= 1'b0;
      sWrite_q <= 1'b0;
    end else begin
      byteIdx_q <= byteIdx_d;
      frameWrite_q <= frameWrite_d;
      regSel_q <= regSel_d;
      frameData_q <= frameData_d;
      crc_q <= crc_d;
      serialActive_q <= serialActive_d;
      sWrite_q <= sWrite_d;
    end
  end

  // register file on the bus, serial writes take priority
  ctrl_type ctrl_q, ctrl_d;
  logic [VEL_W-1:0] velocity_q, velocity_d;
  logic [31:0] prdata_d;
  logic pready_d, pslverr_d, apbDone, mapped;
  logic [POS_W-1:0] count_q;

  assign apbDone = psel && penable && pready;
  assign mapped = (paddr == CTRL_OFS) || (paddr == VEL_OFS) ||
                  (paddr == STAT_OFS);

  always_comb begin
    ctrl_d = ctrl_q;
    velocity_d = velocity_q;
    pready_d = psel && penable && !pready;
    pslverr_d = psel && penable && !pready && !mapped;
    prdata_d = 32'h0000_0000;
    if (psel && penable && !pready) begin
      case (paddr)
        CTRL_OFS: prdata_d = {25'h0, ctrl_q};
        VEL_OFS: prdata_d = {8'h00, velocity_q};
        STAT_OFS: begin
          prdata_d[POS_W-1:0] = count_q;
          prdata_d[STAT_SERIAL_BIT] = serialActive_q;
          prdata_d[STAT_FAULT_BIT] = faultOutput;
          prdata_d[STAT_STILL_BIT] = standstillReduce;
          prdata_d[STAT_POWER_BIT] = powerStageEnable;
        end
        default: prdata_d = 32'h0000_0000;
      endcase
    end
    if (apbDone && pwrite && paddr == CTRL_OFS) begin
      ctrl_d = pwdata[6:0];
    end
    if (apbDone && pwrite && paddr == VEL_OFS) begin
      velocity_d = pwdata[VEL_W-1:0];
    end
    if (sWrite_q && regSel_q == SREG_CTRL) begin
      ctrl_d = frameData_q[6:0];
    end
    if (sWrite_q && regSel_q == SREG_VEL) begin
      // R15 new velocity takes effect at once
      velocity_d = frameData_q[VEL_W-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= CTRL_RESET;
      velocity_q <= '0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      velocity_q <= velocity_d;
      prdata <= prdata_d;
      pready <= pready_d;
      pslverr <= pslverr_d;
    end
  end

  // step source, microstep counter and standstill timer
  logic stepPrev_q, stepRise, stepFall, extStep, genActive, genStep;
  logic stepNow, dirNow, useOverride, stillEnable;
  logic [VEL_W-1:0] velMag, accum_q, accum_d;
  logic [3:0] resolution;
  logic [POS_W-1:0] count_d, increment;
  logic [11:0] idle_q, idle_d;
  logic index_d, still_d, fault_d;
  logic negA_d, negB_d, negA_q, negB_q;
  logic [7:0] magSin, magCos;

  assign stepRise = pinSync_q[PIN_STEP] && !stepPrev_q;
  assign stepFall = !pinSync_q[PIN_STEP] && stepPrev_q;
  assign useOverride = serialActive_q && ctrl_q.pinOverride;
  assign velMag = velocity_q[VEL_W-1] ? (~velocity_q + 1'b1) : velocity_q;
  assign genActive = (velocity_q != '0);

  always_comb begin
    // R1 dual edge option
    extStep = stepRise || (ctrl_q.dualEdge && stepFall);
    // R14 accumulator overflow is a step
    {genStep, accum_d} = {1'b0, accum_q} + {1'b0, velMag};
    if (!genActive) begin
      accum_d = '0;
      genStep = 1'b0;
    end
    // R16 generator replaces external steps while running
    stepNow = genActive ? genStep : extStep;
    // R2 direction taken with the step
    dirNow = genActive ? velocity_q[VEL_W-1] : pinSync_q[PIN_DIR];
    // R8 R20 R6 resolution source
    if (useOverride) begin
      resolution = (ctrl_q.resolution > MRES_MAX) ? MRES_MAX
                                                  : ctrl_q.resolution;
    end else begin
      resolution = pinResolution({pinSync_q[PIN_MSHI], pinSync_q[PIN_MSLO]});
    end
    // R4 increment per resolution
    increment = FULL_STEP_INC >> resolution;
    count_d = count_q;
    if (stepNow) begin
      // R3 R23 count wraps on its width
      count_d = dirNow ? (count_q - increment) : (count_q + increment);
    end
    // R21 index at position zero
    index_d = stepNow && (count_d == '0);
    idle_d = stepNow ? 12'h000 : idle_q;
    if (!stepNow && idle_q != 12'(STANDSTILL_CYC)) begin
      idle_d = idle_q + 1'b1;
    end
    // R17 pin low selects reduction
    stillEnable = useOverride ? ctrl_q.standstillEn : !pinSync_q[PIN_PDN];
    still_d = stillEnable && (idle_q == 12'(STANDSTILL_CYC));
    // R19 error sets, disable clears
    fault_d = pinSync_q[PIN_ERR] ||
              (faultOutput && !pinSync_q[PIN_ENN]);
    negA_d = count_q[9];
    negB_d = count_q[9] ^ count_q[8];
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stepPrev_q <= 1'b0;
      accum_q <= '0;
      count_q <= '0;
      idle_q <= 12'h000;
      rotationIndex <= 1'b0;
      standstillReduce <= 1'b0;
      faultOutput <= 1'b0;
      powerStageEnable <= 1'b0;
      powerdownSerialPinOut <= 1'b1;
      powerdownSerialPinOe <= 1'b0;
      negA_q <= 1'b0;
      negB_q <= 1'b0;
    end else begin
      stepPrev_q <= pinSync_q[PIN_STEP];
      accum_q <= accum_d;
      count_q <= count_d;
      idle_q <= idle_d;
      rotationIndex <= index_d;
      standstillReduce <= still_d;
      faultOutput <= fault_d;
      // R18 disable high turns the stage off
      powerStageEnable <= !pinSync_q[PIN_ENN];
      powerdownSerialPinOut <= 1'b1;
      powerdownSerialPinOe <= 1'b0;
      negA_q <= negA_d;
      negB_q <= negB_d;
    end
  end

  // R5 sine for coil A, cosine for coil B
  sdm_sine_rom u_sine (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .index(tableIndex(count_q)),
    .magnitude(magSin)
  );

  sdm_sine_rom u_cosine (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .index(tableIndex(count_q + QUARTER_OFS)),
    .magnitude(magCos)
  );

  assign coilCurrent = '{negA_q, magSin, negB_q, magCos};

endmodule : sdm_sequencer

// >>> sdm_sequencer_assertions.sv
`timescale 1ns/1ps
module sdm_sequencer_checker
  import sdm_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic stepIn,
  input wire logic driverDisable_n,
  input wire logic driverError,
  input wire logic faultOutput,
  input wire logic rotationIndex,
  input wire logic powerStageEnable,
  input wire logic standstillReduce,
  input wire sdm_pkg::coil_current_type coilCurrent
);
  localparam int QUIET_MIN = STANDSTILL_CYC - 8;
  logic stepLast_q;
  int quietCnt_q;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  // cycles since the step pin last moved
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stepLast_q <= 1'b0;
      quietCnt_q <= 0;
    end else begin
      stepLast_q <= stepIn;
      quietCnt_q <= (stepIn != stepLast_q) ? 0 : quietCnt_q + 1;
    end
  end
  property p_stage_off;
    driverDisable_n [*5] |-> !powerStageEnable;
  endproperty
  a_stage_off: assert property (p_stage_off)
    else $error("power stage on while disabled");
  property p_stage_on;
    !driverDisable_n [*5] |-> powerStageEnable;
  endproperty
  a_stage_on: assert property (p_stage_on)
    else $error("power stage off while enabled");
  property p_fault_set;
    driverError [*5] |-> faultOutput;
  endproperty
  a_fault_set: assert property (p_fault_set)
    else $error("fault not raised on driver error");
  property p_fault_fall;
    $fell(faultOutput) |-> $past(driverDisable_n, 2)
      || $past(driverDisable_n, 3) || $past(driverDisable_n, 4);
  endproperty
  a_fault_fall: assert property (p_fault_fall)
    else $error("fault cleared without disable");
  property p_index_once;
    rotationIndex |=> !rotationIndex;
  endproperty
  a_index_once: assert property (p_index_once)
    else $error("index pulse longer than one cycle");
  property p_index_coil;
    rotationIndex |=> coilCurrent.magA == 8'h00 && coilCurrent.magB == 8'hFF;
  endproperty
  a_index_coil: assert property (p_index_coil)
    else $error("coil currents wrong at position zero");
  property p_still_quiet;
    $rose(standstillReduce) |-> quietCnt_q > QUIET_MIN;
  endproperty
  a_still_quiet: assert property (p_still_quiet)
    else $error("standstill reduction too early");
  property p_apb_wait;
    psel && penable && !pready |=> pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait)
    else $error("bus answer late");
  property p_err_ready;
    pslverr |-> pready && psel && penable;
  endproperty
  a_err_ready: assert property (p_err_ready)
    else $error("error response outside access");
  c_index: cover property (rotationIndex);
  c_fault: cover property ($fell(faultOutput));
  c_still: cover property ($rose(standstillReduce));
  c_err: cover property (pslverr);
endmodule : sdm_sequencer_checker

bind sdm_sequencer sdm_sequencer_checker u_checker (
  .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .stepIn(stepIn),
  .driverDisable_n(driverDisable_n), .driverError(driverError),
  .faultOutput(faultOutput), .rotationIndex(rotationIndex),
  .powerStageEnable(powerStageEnable),
  .standstillReduce(standstillReduce), .coilCurrent(coilCurrent)
);

// >>> sdm_host_model.sv
`timescale 1ns/1ps
module sdm_host_model
  import sdm_pkg::*;
(
  input wire logic core_clk,
  output logic stepIn,
  output logic dirIn,
  output logic serialLine
);
  initial begin
    stepIn = 1'b0;
    dirIn = 1'b0;
    serialLine = 1'b1;
  end
  task automatic waitClk(input int n);
    repeat (n) @(posedge core_clk);
  endtask : waitClk
  task automatic stepEdge(input logic d);
    dirIn <= d;
    waitClk(3);
    stepIn <= ~stepIn;
    waitClk(3);
  endtask : stepEdge
  // 8 bit character, low bit first
  task automatic sendByte(input logic [7:0] b, input int bt);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      serialLine <= f[i];
      waitClk(bt);
    end
  endtask : sendByte
  function automatic logic [7:0] crcAdd(logic [7:0] c, logic [7:0] d);
    for (int j = 0; j < 8; j++) begin
      c = (c[7] ^ d[j]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction : crcAdd
  task automatic sendFrame(input logic [7:0] node, input logic [6:0] regNo,
                           input logic [31:0] v, input logic bad,
                           input int bt);
    logic [7:0] b [8];
    b = '{{4'h0, SYNC_NIBBLE}, node, {1'b1, regNo}, v[31:24], v[23:16],
          v[15:8], v[7:0], 8'h00};
    for (int i = 0; i < 7; i++) begin
      b[7] = crcAdd(b[7], b[i]);
    end
    b[7] = b[7] ^ {7'h00, bad};
    for (int i = 0; i < 8; i++) begin
      sendByte(b[i], bt);
    end
    waitClk(bt * 4);
  endtask : sendFrame
endmodule : sdm_host_model

// >>> sdm_sequencer_bench.sv
`timescale 1ns/1ps
module sdm_sequencer_bench;
  import sdm_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, stepIn, dirIn, pdnIn, pdnOut, pdnOe, line, err;
  logic disN = 1'b0, msLo = 1'b0, msHi = 1'b0, drvErr = 1'b0, pdnLow = 1'b0;
  logic fault, rotIdx, stageEn, still;
  coil_current_type coil;
  int n_mismatch = 0, checks_done = 0, idxSeen = 0, idxExp = 0;
  logic [9:0] expPos = 10'h000, p1;
  assign pdnIn = pdnOe ? pdnOut : (line & ~pdnLow);
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) if (rotIdx === 1'b1) idxSeen++;
  sdm_sequencer u_dut (.core_clk(core_clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .stepIn(stepIn),
    .dirIn(dirIn), .driverDisable_n(disN), .resolutionSelectLo(msLo),
    .resolutionSelectHi(msHi), .powerdownSerialPinIn(pdnIn),
    .powerdownSerialPinOut(pdnOut), .powerdownSerialPinOe(pdnOe),
    .driverError(drvErr), .faultOutput(fault), .rotationIndex(rotIdx),
    .powerStageEnable(stageEn), .standstillReduce(still),
    .coilCurrent(coil));
  sdm_host_model u_host (.core_clk(core_clk), .stepIn(stepIn),
    .dirIn(dirIn), .serialLine(line));
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input string what, input logic [31:0] e,
                       input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask : check
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_mismatch++;
      give_verdict();
    end else @(posedge core_clk);
  endtask : apb
  task automatic status(input logic ser);
    apb(1'b0, STAT_OFS, 32'h0);
    check("count", 32'(expPos), 32'(rd[9:0]));
    check("serial", 32'(ser), 32'(rd[STAT_SERIAL_BIT]));
  endtask : status
  task automatic mv(input logic d, input logic [9:0] inc, input logic dual);
    u_host.stepEdge(d);
    if (!dual) u_host.stepEdge(d);
    expPos = d ? expPos - inc : expPos + inc;
    if (expPos == 10'h000) idxExp++;
  endtask : mv
  task automatic rate(input logic [31:0] v, input int lo, input int hi);
    logic signed [9:0] dlt;
    apb(1'b1, VEL_OFS, v);
    apb(1'b0, STAT_OFS, 32'h0);
    p1 = rd[9:0];
    repeat (160) @(posedge core_clk);
    apb(1'b0, STAT_OFS, 32'h0);
    dlt = rd[9:0] - p1;
    check("rate", 32'h1, 32'(dlt >= lo && dlt <= hi));
  endtask : rate
  function automatic logic [9:0] pinInc(input logic [1:0] code);
    case (code)
      2'b00: return 10'h020;
      2'b01: return 10'h080;
      2'b10: return 10'h040;
      default: return 10'h010;
    endcase
  endfunction : pinInc
  // host keeps its own control copy
  function automatic logic [31:0] ctrlWord(input logic [3:0] res);
    return {25'h0, 1'b0, res, 2'b11};
  endfunction : ctrlWord
  task automatic ser(input logic [6:0] r, input logic [31:0] v, input int bt);
    u_host.sendFrame(NODE_ADDR, r, v, 1'b0, bt);
  endtask : ser
  initial begin
    void'($urandom(32'hCAFF));
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    status(1'b0);
    apb(1'b0, 8'h0C, 32'h0);
    check("unmapped", 32'h1, 32'(err));
    check("pin", 32'h2, 32'({pdnOut, pdnOe}));
    pdnLow <= 1'b1;
    repeat (STANDSTILL_CYC + 20) @(posedge core_clk);
    check("still", 32'h1, 32'(still));
    mv(1'b0, pinInc(2'b00), 1'b0);
    check("still", 32'h0, 32'(still));
    pdnLow <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      {msHi, msLo} <= c[1:0];
      repeat (4) @(posedge core_clk);
      for (int k = 0; k < 2 + $urandom % 4; k++) begin
        mv(1'($urandom), pinInc(c[1:0]), 1'b0);
      end
      status(1'b0);
    end
    drvErr <= 1'b1;
    repeat (6) @(posedge core_clk);
    check("fault", 32'h1, 32'(fault));
    drvErr <= 1'b0;
    disN <= 1'b1;
    repeat (6) @(posedge core_clk);
    check("fault", 32'h0, 32'(fault));
    check("stage", 32'h0, 32'(stageEn));
    disN <= 1'b0;
    repeat (STANDSTILL_CYC * 12) @(posedge core_clk);
    u_host.sendFrame(NODE_ADDR, SREG_CTRL, ctrlWord(4'h8), 1'b1, 16);
    u_host.sendFrame(8'h01, SREG_CTRL, ctrlWord(4'h8), 1'b0, 16);
    repeat (2000) @(posedge core_clk);
    status(1'b0);
    ser(SREG_CTRL, ctrlWord(4'h8), 250);
    status(1'b1);
    apb(1'b0, CTRL_OFS, 32'h0);
    check("ctrl", ctrlWord(4'h8), rd);
    for (int r = 0; r <= 8; r++) begin
      ser(SREG_CTRL, ctrlWord(4'(r)), 16);
      mv(1'b0, 10'h100 >> r, 1'b1);
      status(1'b1);
      mv(1'b1, 10'h100 >> r, 1'b1);
    end
    ser(SREG_CTRL, ctrlWord(4'h4), 16);
    while (expPos[7:0] != 8'h00) mv(1'b0, 10'h010, 1'b1);
    ser(SREG_CTRL, ctrlWord(4'h0), 16);
    repeat (4) mv(1'b0, 10'h100, 1'b1);
    status(1'b1);
    check("coil", 32'({expPos[9], (expPos[8] ? 8'hFF : 8'h00), ^expPos[9:8],
      (expPos[8] ? 8'h00 : 8'hFF)}), 32'(coil));
    check("index", 32'(idxExp), 32'(idxSeen));
    ser(SREG_CTRL, ctrlWord(4'h8), 16);
    ser(SREG_VEL, 32'h0000_1234, 16);
    apb(1'b0, VEL_OFS, 32'h0);
    check("vel", 32'h0000_1234, rd);
    rate(32'h0010_0000, 9, 12);
    rate(32'h00F0_0000, -12, -9);
    apb(1'b1, VEL_OFS, 32'h0);
    apb(1'b0, STAT_OFS, 32'h0);
    p1 = rd[9:0];
    u_host.stepEdge(1'b0);
    apb(1'b0, STAT_OFS, 32'h0);
    check("ext", 32'(p1 + 10'h001), 32'(rd[9:0]));
    give_verdict();
  end
endmodule : sdm_sequencer_bench
